// ---- rtl/flash_reset_host.sv ----
// Host controller that sequences cold and warm restart of a parallel flash.
`include "rst_seq_map.svh"
`default_nettype none
module flash_reset_host
    import rst_seq_pkg::*;
#(
    parameter int SETTLE_CYC = `SUPPLY_SETTLE_CYC,
    parameter int RECOVER_CYC = `RECOVERY_CYC
)(
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic SUPPLY_GOOD,
    input wire logic WARM_REQ,
    input wire logic DONE_FLAG_N,
    input wire logic ADDR_CHANGE,
    output logic WARM_RESTART_OUT_N,
    output logic CHIP_SELECT_N,
    output logic DEVICE_READY,
    output logic DEVICE_ASLEEP
);
    localparam int PULSE_CYC = `PULSE_CYC;
    localparam int RELEASE_CYC = `RELEASE_CYC;
    localparam int SLEEP_CYC = `SLEEP_CYC;

    // The pulse alone never reaches the recovery time, so recovery is waited explicitly.
    // This check runs at elaboration, so a bad parameter set never reaches simulation.
    if (SETTLE_CYC < 1 || RECOVER_CYC <= PULSE_CYC)
    begin
        $error("flash_reset_host: timing parameters out of range.");
    end

    state_type s_q, s_d;

    // Next-state logic for the whole sequencer.
    always_comb
    begin
        s_d = s_q;
        s_d.count = s_q.count + 32'h1;
        unique case (s_q.phase)
            ST_POWER:
            begin
                // Restart held low through the settle time; the device ignores it meanwhile.
                s_d.restart_n = 1'b0;
                s_d.select_n = 1'b1;
                if (!SUPPLY_GOOD)
                    s_d.count = 32'h0;
                else if (s_q.count >= 32'(SETTLE_CYC - 1))
                begin
                    // Recovery restarts from the settle end since restart stayed low.
                    s_d.phase = ST_RECOVER;
                    s_d.count = 32'h0;
                end
            end
            ST_PULSE:
            begin
                s_d.restart_n = 1'b0;
                if (s_q.count >= 32'(PULSE_CYC - 1))
                begin
                    s_d.phase = ST_RECOVER;
                    s_d.count = 32'(PULSE_CYC);
                end
            end
            ST_RECOVER:
            begin
                // A busy device keeps us here, so a held restart never ends early.
                if (s_q.count >= 32'(RECOVER_CYC - 1) && DONE_FLAG_N)
                begin
                    s_d.phase = ST_RELEASE;
                    s_d.restart_n = 1'b1;
                    s_d.count = 32'h0;
                end
            end
            ST_RELEASE:
            begin
                if (s_q.count >= 32'(RELEASE_CYC - 1))
                begin
                    s_d.phase = ST_READY;
                    s_d.select_n = 1'b0;
                    s_d.ready = 1'b1;
                    s_d.warm = 1'b1;
                    s_d.idle = 32'h0;
                end
            end
            ST_READY:
            begin
                // Select stays low so the device fetches the current address after restart.
                if (!SUPPLY_GOOD)
                begin
                    s_d.phase = ST_POWER;
                    s_d.count = 32'h0;
                    // Pins take their power-up levels at once, never select low in restart.
                    s_d.restart_n = 1'b0;
                    s_d.select_n = 1'b1;
                    s_d.ready = 1'b0;
                    s_d.warm = 1'b0;
                end
                else if (WARM_REQ)
                begin
                    s_d.phase = ST_PULSE;
                    s_d.count = 32'h0;
                    s_d.ready = 1'b0;
                    s_d.restart_n = 1'b0;
                end
            end
        endcase
        // Track address stability for the automatic sleep indication.
        if (s_q.phase != ST_READY || ADDR_CHANGE)
        begin
            s_d.idle = 32'h0;
            s_d.asleep = 1'b0;
        end
        else if (s_q.idle >= 32'(SLEEP_CYC - 1))
            s_d.asleep = 1'b1;
        else
            s_d.idle = s_q.idle + 32'h1;
    end

    // State register with synchronous reset.
    always_ff @(posedge CLK)
    begin
        if (!RESET_N)
        begin
            s_q.phase <= ST_POWER;
            s_q.count <= 32'h0;
            s_q.restart_n <= 1'b0;
            s_q.select_n <= 1'b1;
            s_q.ready <= 1'b0;
            s_q.warm <= 1'b0;
            s_q.idle <= 32'h0;
            s_q.asleep <= 1'b0;
        end
        else
            s_q <= s_d;
    end

    assign WARM_RESTART_OUT_N = s_q.restart_n;
    assign CHIP_SELECT_N = s_q.select_n;
    assign DEVICE_READY = s_q.ready;
    assign DEVICE_ASLEEP = s_q.asleep;

    // Select never falls unless restart was high the cycle before.
    property p_release;
        @(posedge CLK) disable iff (!RESET_N)
        $fell(s_q.select_n) |-> $past(s_q.restart_n);
    endproperty
    release_gap_a: assert property (p_release) else $error("Select fell without release time.");

    pulse_width_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $fell(s_q.restart_n) && s_q.phase == ST_PULSE |-> !s_q.restart_n [*8])
        else $error("Restart pulse too short.");

    select_high_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !s_q.restart_n && !s_q.warm |-> s_q.select_n)
        else $error("Select low during restart.");

    ready_select_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.ready |-> !s_q.select_n && s_q.restart_n)
        else $error("Ready without released pins.");

    sleep_ready_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.asleep |-> s_q.phase == ST_READY)
        else $error("Sleep outside ready.");

    supply_drop_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !SUPPLY_GOOD && s_q.phase == ST_POWER |=> s_q.count == 32'h0)
        else $error("Settle count not restarted.");

    recover_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_RECOVER && !DONE_FLAG_N |=> s_q.phase == ST_RECOVER)
        else $error("Left recovery while busy.");

    warm_entry_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_READY && SUPPLY_GOOD && WARM_REQ |=> !s_q.restart_n && !s_q.ready)
        else $error("Warm restart not started.");

    // Power-up holds restart low and select high while the device loads itself.
    cold_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_POWER |-> !s_q.restart_n && s_q.select_n)
        else $error("Pins not at power-up levels.");

    // Supply loss in ready sends the sequencer back to a full cold start.
    ready_supply_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_READY && !SUPPLY_GOOD |=> s_q.phase == ST_POWER && !s_q.ready)
        else $error("Supply loss not handled.");

    // Recovery done and device idle releases the restart pin on the next edge.
    release_done_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_RECOVER && s_q.count >= 32'(RECOVER_CYC - 1) && DONE_FLAG_N
        |=> s_q.restart_n)
        else $error("Restart not released.");

    // An address change always wakes the sleep indication.
    sleep_wake_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        ADDR_CHANGE |=> !s_q.asleep)
        else $error("Sleep kept after address change.");

    // The restart pin is low for every cycle of the pulse phase.
    pulse_low_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        s_q.phase == ST_PULSE |-> !s_q.restart_n)
        else $error("Restart high during pulse.");
endmodule
`default_nettype wire

// ---- rtl/rst_seq_map.svh ----
// Timing constants for the host-side flash reset sequencer.
`ifndef RST_SEQ_MAP_SVH
`define RST_SEQ_MAP_SVH
`define CLK_PERIOD_PS 5000
`define SUPPLY_SETTLE_US 300
`define RECOVERY_US 35
`define PULSE_NS 200
`define RELEASE_NS 50
`define SLEEP_MAX_US 8
`define SUPPLY_SETTLE_CYC ((`SUPPLY_SETTLE_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RECOVERY_CYC ((`RECOVERY_US * 1000000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PULSE_CYC ((`PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define RELEASE_CYC ((`RELEASE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SLEEP_CYC ((`SLEEP_MAX_US * 1000000) / `CLK_PERIOD_PS)
`endif

// ---- rtl/rst_seq_pkg.sv ----
// Types for the host-side flash reset sequencer.
`default_nettype none
package rst_seq_pkg;
    typedef enum logic [2:0] {
        ST_POWER,
        ST_PULSE,
        ST_RECOVER,
        ST_RELEASE,
        ST_READY
    } phase_type;
    typedef struct packed {
        phase_type phase;
        logic [31:0] count;
        logic restart_n;
        logic select_n;
        logic ready;
        logic warm;
        logic [31:0] idle;
        logic asleep;
    } state_type;
endpackage
`default_nettype wire

// ---- testbench/flash_dev_model.sv ----
// Behavioural flash device that answers supply and restart changes.
`default_nettype none
module flash_dev_model #(
    parameter int SETTLE = 50,
    parameter int RECOV = 60
)(
    input wire logic clk,
    input wire logic supply,
    input wire logic restart_n,
    output logic done_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic sup_q = 0;
    logic rst_q = 1;
    // Busy low for RECOV cycles after a restart falling edge seen while idle; a held restart pin leaves it high.
    assign done_n = (cnt == 0);
    // Restart edges are ignored until cold init ends, so an early one is lost.
    always @(posedge clk)
    begin
        sup_q <= supply;
        rst_q <= restart_n;
        if (!supply)
            cnt <= 0;
        else if (!sup_q)
            cnt <= SETTLE;
        else if (cnt != 0)
            cnt <= cnt - 1;
        else if (rst_q && !restart_n)
            cnt <= RECOV;
    end
endmodule
`default_nettype wire

// ---- testbench/test_flash_reset_host.sv ----
// Self-checking bench for the flash restart sequencer.
`default_nettype none
module test_flash_reset_host;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SETTLE = 50;
    localparam int RECOV = 60;
    localparam int SLEEP = 1600;
    logic CLK = 0;
    logic RESET_N = 0;
    logic SUPPLY_GOOD = 0;
    logic WARM_REQ = 0;
    logic ADDR_CHANGE = 0;
    logic DONE_FLAG_N, WARM_RESTART_OUT_N, CHIP_SELECT_N, DEVICE_READY, DEVICE_ASLEEP;
    int n_errors = 0;
    int compares = 0;
    int cyc = 0;
    int low = 0;
    int high = 0;
    logic sel_q = 1;
    always #2.5 CLK = ~CLK;
    flash_reset_host #(.SETTLE_CYC(SETTLE), .RECOVER_CYC(RECOV)) flash_reset_host_inst (
        .CLK(CLK), .RESET_N(RESET_N), .SUPPLY_GOOD(SUPPLY_GOOD), .WARM_REQ(WARM_REQ),
        .DONE_FLAG_N(DONE_FLAG_N), .ADDR_CHANGE(ADDR_CHANGE),
        .WARM_RESTART_OUT_N(WARM_RESTART_OUT_N), .CHIP_SELECT_N(CHIP_SELECT_N),
        .DEVICE_READY(DEVICE_READY), .DEVICE_ASLEEP(DEVICE_ASLEEP));
    flash_dev_model #(.SETTLE(SETTLE), .RECOV(RECOV)) flash_dev_model_inst (
        .clk(CLK), .supply(SUPPLY_GOOD), .restart_n(WARM_RESTART_OUT_N),
        .done_n(DONE_FLAG_N));
    task check(string what, logic [31:0] exp, logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task close_out();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Counts restart-low cycles, flags select falling too soon after release, and cuts hangs.
    always @(posedge CLK)
    begin
        cyc++;
        if (!WARM_RESTART_OUT_N)
            low++;
        high = (WARM_RESTART_OUT_N === 1'b1) ? high + 1 : 0;
        // Select may stay low through a warm restart, but may only fall after release time.
        if (RESET_N && sel_q === 1'b1 && CHIP_SELECT_N === 1'b0)
            check("release before select", 32'h1, 32'(high >= 10));
        sel_q = CHIP_SELECT_N;
        if (cyc == 20000)
        begin
            n_errors++;
            close_out();
        end
    end
    task wait_ready();
        for (int i = 0; i < 400 && DEVICE_READY !== 1'b1; i++)
            @(negedge CLK);
    endtask
    task cold_start();
        SUPPLY_GOOD = 1;
        low = 0;
        wait_ready();
        check("ready", 32'h1, DEVICE_READY);
        check("cold low long", 32'h1, 32'(low >= SETTLE + RECOV));
        check("select", 32'h0, CHIP_SELECT_N);
    endtask
    task warm_restart();
        WARM_REQ = 1;
        @(negedge CLK);
        WARM_REQ = 0;
        low = 0;
        @(negedge CLK);
        check("ready drop", 32'h0, DEVICE_READY);
        wait_ready();
        check("warm ready", 32'h1, DEVICE_READY);
        check("warm low long", 32'h1, 32'(low >= RECOV));
        check("busy flag", 32'h1, DONE_FLAG_N);
    endtask
    task sleep_entry();
        ADDR_CHANGE = 1;
        @(negedge CLK);
        ADDR_CHANGE = 0;
        repeat (SLEEP - 20) @(negedge CLK);
        check("early sleep", 32'h0, DEVICE_ASLEEP);
        repeat (40) @(negedge CLK);
        check("sleep", 32'h1, DEVICE_ASLEEP);
        ADDR_CHANGE = 1;
        @(negedge CLK);
        ADDR_CHANGE = 0;
        repeat (2) @(negedge CLK);
        check("wake", 32'h0, DEVICE_ASLEEP);
    endtask
    task supply_loss();
        SUPPLY_GOOD = 0;
        repeat (3) @(negedge CLK);
        check("lost ready", 32'h0, DEVICE_READY);
        cold_start();
    endtask
    initial
    begin
        repeat (6) @(negedge CLK);
        RESET_N = 1;
        cold_start();
        warm_restart();
        sleep_entry();
        supply_loss();
        close_out();
    end
endmodule
`default_nettype wire
